/* verilog/fcsp_regs.svh */
`ifndef FCSP_REGS_SVH
`define FCSP_REGS_SVH

// Register byte offsets on the bus
`define FCSP_OFF_PROT     8'h00
`define FCSP_OFF_STAT     8'h04
`define FCSP_OFF_CMD      8'h08
`define FCSP_OFF_ADDR     8'h0c
`define FCSP_OFF_DATA     8'h10
`define FCSP_OFF_SEC      8'h14

// Protection register fields
`define FCSP_PROT_DIS_BIT 0
`define FCSP_PROT_BS_MSB  7
`define FCSP_PROT_BS_LSB  1

// Status register fields
`define FCSP_STAT_CBEF    7
`define FCSP_STAT_CCF     6
`define FCSP_STAT_PVIOL   5
`define FCSP_STAT_ACCERR  4
`define FCSP_STAT_BLANK   2

// Reset values
`define FCSP_RST_CBEF     1'b1
`define FCSP_RST_ADDR     16'h0000
`define FCSP_RST_DATA     8'h00

// Command codes
`define FCSP_CMD_BLANK    8'h05
`define FCSP_CMD_BYTE     8'h20
`define FCSP_CMD_BURST    8'h25
`define FCSP_CMD_PAGE     8'h40
`define FCSP_CMD_MASS     8'h41

// Page size is 512 bytes: 9 offset bits below the page number
`define FCSP_PAGE_BITS    9
`define FCSP_PAGE_OFS_MAX 9'h1ff

// Security code written after a successful blank check
`define FCSP_SEC_UNSECURE 2'h2

`endif

/* verilog/fcsp_pkg.sv */
`default_nettype none

package fcsp_pkg;

   // Array operations carried by a recognised command
   typedef enum logic [2:0] {
      FCSP_OP_NONE,
      FCSP_OP_BLANK,
      FCSP_OP_BYTE,
      FCSP_OP_BURST,
      FCSP_OP_PAGE,
      FCSP_OP_MASS
   } fcsp_op_t;

   // Progress of the software command sequence
   typedef enum logic [1:0] {
      FCSP_SEQ_IDLE,
      FCSP_SEQ_DATA,
      FCSP_SEQ_CMD
   } fcsp_seq_t;

endpackage : fcsp_pkg

`default_nettype wire

/* verilog/fcsp_cmd_decode.sv */
`include "fcsp_regs.svh"
`default_nettype none

module fcsp_cmd_decode
   import fcsp_pkg::*;
(
   input  wire logic [7:0] code_i,
   output fcsp_op_t        op_o,
   output logic            legal_o,
   output logic            modify_o
);

   ////////////////////////////////////////////////////////////////////////
   // Five codes map to an operation; all others are illegal
   always_comb
   begin
      case (code_i)
         `FCSP_CMD_BLANK: op_o = FCSP_OP_BLANK;
         `FCSP_CMD_BYTE:  op_o = FCSP_OP_BYTE;
         `FCSP_CMD_BURST: op_o = FCSP_OP_BURST;
         `FCSP_CMD_PAGE:  op_o = FCSP_OP_PAGE;
         `FCSP_CMD_MASS:  op_o = FCSP_OP_MASS;
         default:         op_o = FCSP_OP_NONE;
      endcase
   end

   // Blank check reads only; everything else alters the array
   assign legal_o  = (op_o != FCSP_OP_NONE);
   assign modify_o = legal_o && (op_o != FCSP_OP_BLANK);

endmodule : fcsp_cmd_decode

`default_nettype wire

/* verilog/fcsp_protect_check.sv */
`include "fcsp_regs.svh"
`default_nettype none

module fcsp_protect_check
   import fcsp_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [6:0]        bsel_i,
   input  wire logic              disable_i,
   input  wire fcsp_op_t          op_i,
   output logic                   viol_o
);

   logic [ADDR_W-1:0] unprot_end;
   logic [ADDR_W-1:0] page_end;
   logic              in_block;

   ////////////////////////////////////////////////////////////////////////
   // Last unprotected byte; the protected block runs to the top
   assign unprot_end = ADDR_W'({bsel_i, `FCSP_PAGE_OFS_MAX});
   // A page erase touches its whole page, so test the page's last byte
   assign page_end   = {addr_i[ADDR_W-1:`FCSP_PAGE_BITS],
                        `FCSP_PAGE_OFS_MAX};
   assign in_block   = (op_i == FCSP_OP_PAGE) ? (page_end > unprot_end)
                                              : (addr_i > unprot_end);

   // Mass erase hits the block whenever any protection is active
   always_comb
   begin
      viol_o = 1'b0;
      if (!disable_i)
      begin
         case (op_i)
            FCSP_OP_BYTE,
            FCSP_OP_BURST,
            FCSP_OP_PAGE: viol_o = in_block;
            FCSP_OP_MASS: viol_o = 1'b1;
            default:      viol_o = 1'b0;
         endcase
      end
   end

endmodule : fcsp_protect_check

`default_nettype wire

/* verilog/fcsp_ctrl.sv */
// The register addresses and the Wishbone register port are this design's own decisions.
`include "fcsp_regs.svh"
`default_nettype none

module fcsp_ctrl
   import fcsp_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone classic slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Images captured from the array at reset
   input  wire logic [7:0]        nv_protect_image_i,
   input  wire logic [1:0]        nv_security_i,
   // Debug access to protection
   input  wire logic              dbg_prot_we_i,
   input  wire logic [7:0]        dbg_prot_data_i,
   // System conditions
   input  wire logic              clk_div_ready_i,
   input  wire logic              stop_mode_i,
   // Array engine
   output logic                   arr_start_o,
   output logic                   arr_abort_o,
   output fcsp_op_t               arr_op_o,
   output logic      [ADDR_W-1:0] arr_addr_o,
   output logic      [7:0]        arr_data_o,
   input  wire logic              arr_done_i,
   input  wire logic              arr_blank_i,
   // Security state for the rest of the chip
   output logic      [1:0]        security_state_code_o
);

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0]        prot_q,     prot_d;
   logic              cbef_q,     cbef_d;
   logic              pviol_q,    pviol_d;
   logic              accerr_q,   accerr_d;
   logic              blank_q,    blank_d;
   fcsp_seq_t         seq_q,      seq_d;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0]        data_q;
   logic [7:0]        code_q;
   fcsp_op_t          buf_op_q;
   logic [ADDR_W-1:0] buf_addr_q;
   logic [7:0]        buf_data_q;
   logic              active_q,   active_d;
   fcsp_op_t          act_op_q;
   logic [1:0]        sec_q;
   logic              ack_q;
   logic [31:0]       dat_q,      dat_d;
   logic              start_q;
   logic              abort_q;

   // Bus decode
   logic              req;
   logic              wr;
   logic              wr_b0;
   logic              hit_prot, hit_stat, hit_cmd;
   logic              hit_addr, hit_data, hit_sec;
   logic              ccf;

   // Command evaluation
   fcsp_op_t          dec_op;
   logic              dec_legal;
   logic              dec_modify;
   fcsp_op_t          pend_op;
   logic              pend_modify;
   logic              pend_viol;
   logic              launch;
   logic              launch_seq_bad;
   logic              launch_div_bad;
   logic              launch_busy_bad;
   logic              launch_ok;
   logic              launch_viol;
   logic              transfer;
   logic              stop_abort;
   logic              blank_done;
   logic              prot_sw_ok;

   ////////////////////////////////////////////////////////////////////////
   // Single-cycle request qualifier: acts once, ack follows next edge
   assign req      = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr       = req && wb_we_i;
   assign wr_b0    = wr && wb_sel_i[0];
   assign hit_prot = (wb_adr_i == `FCSP_OFF_PROT);
   assign hit_stat = (wb_adr_i == `FCSP_OFF_STAT);
   assign hit_cmd  = (wb_adr_i == `FCSP_OFF_CMD);
   assign hit_addr = (wb_adr_i == `FCSP_OFF_ADDR);
   assign hit_data = (wb_adr_i == `FCSP_OFF_DATA);
   assign hit_sec  = (wb_adr_i == `FCSP_OFF_SEC);

   // Complete means nothing buffered and nothing running
   assign ccf = cbef_q && !active_q;

   ////////////////////////////////////////////////////////////////////////
   // Command decode of the written code and the one pending launch
   fcsp_cmd_decode u_decode_wr
   (
      .code_i   (wb_dat_i[7:0]),
      .op_o     (dec_op),
      .legal_o  (dec_legal),
      .modify_o (dec_modify)
   );

   fcsp_cmd_decode u_decode_pend
   (
      .code_i   (code_q),
      .op_o     (pend_op),
      .legal_o  (),
      .modify_o (pend_modify)
   );

   fcsp_protect_check #(
      .ADDR_W    (ADDR_W)
   ) u_protect (
      .addr_i    (addr_q),
      .bsel_i    (prot_q[`FCSP_PROT_BS_MSB:`FCSP_PROT_BS_LSB]),
      .disable_i (prot_q[`FCSP_PROT_DIS_BIT]),
      .op_i      (pend_op),
      .viol_o    (pend_viol)
   );

   ////////////////////////////////////////////////////////////////////////
   // Launch checks, in priority order; the first failing one wins
   assign launch          = wr_b0 && hit_stat
                            && wb_dat_i[`FCSP_STAT_CBEF];
   assign launch_seq_bad  = (seq_q != FCSP_SEQ_CMD) || !cbef_q;
   assign launch_div_bad  = pend_modify && !clk_div_ready_i;
   // While running, only burst behind burst may queue
   assign launch_busy_bad = active_q && !((pend_op == FCSP_OP_BURST)
                            && (act_op_q == FCSP_OP_BURST));
   assign launch_viol     = launch && !launch_seq_bad
                            && !launch_div_bad && !launch_busy_bad
                            && pend_viol;
   assign launch_ok       = launch && !launch_seq_bad
                            && !launch_div_bad && !launch_busy_bad
                            && !pend_viol;

   // Buffer feeds the array when it is free or just finishing
   assign transfer   = !cbef_q && (!active_q || arr_done_i)
                       && !stop_mode_i;
   assign stop_abort = stop_mode_i && (active_q || !cbef_q);
   assign blank_done = active_q && arr_done_i
                       && (act_op_q == FCSP_OP_BLANK);

   // Upward-only: enabled, stays enabled, strictly smaller boundary
   assign prot_sw_ok = !prot_q[`FCSP_PROT_DIS_BIT]
                       && !wb_dat_i[`FCSP_PROT_DIS_BIT]
                       && (wb_dat_i[`FCSP_PROT_BS_MSB:`FCSP_PROT_BS_LSB]
                           < prot_q[`FCSP_PROT_BS_MSB:`FCSP_PROT_BS_LSB]);

   ////////////////////////////////////////////////////////////////////////
   // Protection register next value; debug beats software
   always_comb
   begin
      prot_d = prot_q;
      if (dbg_prot_we_i)
         prot_d = dbg_prot_data_i;
      else if (wr_b0 && hit_prot && prot_sw_ok)
         prot_d = wb_dat_i[7:0];
   end

   // Sequence tracker: data write, then code, then launch
   always_comb
   begin
      seq_d = seq_q;
      if (launch || stop_abort)
         seq_d = FCSP_SEQ_IDLE;
      else if (wr_b0 && hit_data && cbef_q)
         seq_d = FCSP_SEQ_DATA;
      else if (wr_b0 && hit_cmd)
      begin
         case (seq_q)
            FCSP_SEQ_DATA: seq_d = dec_legal ? FCSP_SEQ_CMD
                                             : FCSP_SEQ_IDLE;
            default:       seq_d = FCSP_SEQ_IDLE;
         endcase
      end
   end

   // Sticky error flags: a new event outranks a software clear
   always_comb
   begin
      accerr_d = accerr_q;
      pviol_d  = pviol_q;
      if (wr_b0 && hit_stat && wb_dat_i[`FCSP_STAT_ACCERR])
         accerr_d = 1'b0;
      if (wr_b0 && hit_stat && wb_dat_i[`FCSP_STAT_PVIOL])
         pviol_d = 1'b0;
      if (launch && (launch_seq_bad || launch_div_bad || launch_busy_bad))
         accerr_d = 1'b1;
      if (wr_b0 && hit_cmd && (!dec_legal || seq_q != FCSP_SEQ_DATA))
         accerr_d = 1'b1;
      if (wr_b0 && hit_data && !cbef_q)
         accerr_d = 1'b1;
      if (stop_abort)
         accerr_d = 1'b1;
      if (launch_viol)
         pviol_d = 1'b1;
   end

   // Buffer, execution and blank flag bookkeeping
   always_comb
   begin
      cbef_d   = cbef_q;
      active_d = active_q;
      blank_d  = blank_q;
      if (active_q && arr_done_i)
         active_d = 1'b0;
      if (launch_ok)
      begin
         cbef_d  = 1'b0;
         blank_d = 1'b0;
      end
      if (transfer)
      begin
         cbef_d   = 1'b1;
         active_d = 1'b1;
      end
      if (stop_abort)
      begin
         cbef_d   = 1'b1;
         active_d = 1'b0;
      end
      if (blank_done)
         blank_d = arr_blank_i;
   end

   // Read mux; command register and reserved bits read zero
   always_comb
   begin
      dat_d = 32'h0000_0000;
      if (req && !wb_we_i)
      begin
         if (hit_prot)
            dat_d[7:0] = prot_q;
         else if (hit_stat)
            dat_d[7:0] = {cbef_q, ccf, pviol_q, accerr_q,
                          1'b0, blank_q, 2'b00};
         else if (hit_addr)
            dat_d[ADDR_W-1:0] = addr_q;
         else if (hit_data)
            dat_d[7:0] = data_q;
         else if (hit_sec)
            dat_d[1:0] = sec_q;
         // Command offset and unmapped offsets return zero
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake and status flags
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q    <= 1'b0;
         dat_q    <= 32'h0000_0000;
         cbef_q   <= `FCSP_RST_CBEF;
         pviol_q  <= 1'b0;
         accerr_q <= 1'b0;
         blank_q  <= 1'b0;
         seq_q    <= FCSP_SEQ_IDLE;
         active_q <= 1'b0;
      end
      else
      begin
         ack_q    <= req;
         dat_q    <= dat_d;
         cbef_q   <= cbef_d;
         pviol_q  <= pviol_d;
         accerr_q <= accerr_d;
         blank_q  <= blank_d;
         seq_q    <= seq_d;
         active_q <= active_d;
      end
   end

   // Images are sampled while reset is held, not forced by it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prot_q <= nv_protect_image_i;
         sec_q  <= nv_security_i;
      end
      else
      begin
         prot_q <= prot_d;
         if (blank_done && arr_blank_i)
            sec_q <= `FCSP_SEC_UNSECURE;
      end
   end

   // Software-side command operands
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         addr_q <= `FCSP_RST_ADDR;
         data_q <= `FCSP_RST_DATA;
         code_q <= 8'h00;
      end
      else
      begin
         if (wr_b0 && hit_addr)
            addr_q <= wb_dat_i[ADDR_W-1:0];
         if (wr_b0 && hit_data && cbef_q)
            data_q <= wb_dat_i[7:0];
         if (wr_b0 && hit_cmd)
            code_q <= wb_dat_i[7:0];
      end
   end

   // One-entry command buffer, filled only by an accepted launch
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         buf_op_q   <= FCSP_OP_NONE;
         buf_addr_q <= `FCSP_RST_ADDR;
         buf_data_q <= `FCSP_RST_DATA;
      end
      else if (launch_ok)
      begin
         buf_op_q   <= pend_op;
         buf_addr_q <= addr_q;
         buf_data_q <= data_q;
      end
   end

   // Array side: start pulses on transfer, abort on stop while the array runs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         start_q    <= 1'b0;
         abort_q    <= 1'b0;
         act_op_q   <= FCSP_OP_NONE;
         arr_addr_o <= `FCSP_RST_ADDR;
         arr_data_o <= `FCSP_RST_DATA;
      end
      else
      begin
         start_q <= transfer;
         abort_q <= stop_abort && active_q;
         if (transfer)
         begin
            act_op_q   <= buf_op_q;
            arr_addr_o <= buf_addr_q;
            arr_data_o <= buf_data_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flops
   assign wb_ack_o              = ack_q;
   assign wb_dat_o              = dat_q;
   assign arr_start_o           = start_q;
   assign arr_abort_o           = abort_q;
   assign arr_op_o              = act_op_q;
   assign security_state_code_o = sec_q;

endmodule : fcsp_ctrl

`default_nettype wire

/* dv/fcsp_ctrl_sva.sv */
`include "fcsp_regs.svh"
`default_nettype none

module fcsp_ctrl_sva
   import fcsp_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [7:0]        wb_adr_i,
   input wire logic [3:0]        wb_sel_i,
   input wire logic [31:0]       wb_dat_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   input wire logic [7:0]        nv_protect_image_i,
   input wire logic [1:0]        nv_security_i,
   input wire logic              dbg_prot_we_i,
   input wire logic [7:0]        dbg_prot_data_i,
   input wire logic              clk_div_ready_i,
   input wire logic              stop_mode_i,
   input wire logic              arr_start_o,
   input wire logic              arr_abort_o,
   input wire fcsp_op_t          arr_op_o,
   input wire logic [ADDR_W-1:0] arr_addr_o,
   input wire logic [7:0]        arr_data_o,
   input wire logic              arr_done_i,
   input wire logic              arr_blank_i,
   input wire logic [1:0]        security_state_code_o
);
   logic busy_q;
   wire  rd_ack = wb_ack_o && !wb_we_i;

   ////////////////////////////////////////////////////////////////////////////
   // Array activity as seen at the ports; abort ends it like done
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         busy_q <= 1'b0;
      else if (arr_start_o)
         busy_q <= 1'b1;
      else if (arr_done_i || arr_abort_o)
         busy_q <= 1'b0;
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // A taken request, and a status read taken while the array works
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence stat_busy_s;
      req_s ##0 (!wb_we_i && wb_adr_i == `FCSP_OFF_STAT && busy_q
         && !arr_abort_o);
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   chk_ack_next: assert property (req_s |=> wb_ack_o)
      else $error("ack not one cycle after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   chk_cmd_zero: assert property (
      rd_ack && wb_adr_i == `FCSP_OFF_CMD |-> wb_dat_o == 32'h0)
      else $error("command register read not zero");
   chk_stat_fixed: assert property (
      rd_ack && wb_adr_i == `FCSP_OFF_STAT |-> (wb_dat_o & 32'hffffff0b) == 0)
      else $error("status fixed bits not zero");
   chk_busy_ccf: assert property (stat_busy_s |=> !wb_dat_o[6])
      else $error("complete flag set while array busy");
   chk_one_start: assert property (arr_start_o |-> !busy_q)
      else $error("start while array busy");
   chk_start_op: assert property (arr_start_o |-> arr_op_o != FCSP_OP_NONE)
      else $error("start without operation");
   chk_abort_why: assert property (
      arr_abort_o |-> $past(stop_mode_i) && $past(busy_q || arr_start_o))
      else $error("abort without stop during command");
   chk_sec_blank: assert property (
      !$past(rst_i) && $changed(security_state_code_o) |->
      $past(arr_done_i && arr_blank_i) && $past(arr_op_o) == FCSP_OP_BLANK
      && security_state_code_o == `FCSP_SEC_UNSECURE)
      else $error("security changed without blank result");
endmodule : fcsp_ctrl_sva

bind fcsp_ctrl fcsp_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

`default_nettype wire

/* dv/fcsp_ctrl_tb.sv */
`include "fcsp_regs.svh"
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end

module fcsp_ctrl_tb
   import fcsp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, dbg_we = 1'b0;
   logic        div_ok = 1'b1, stop = 1'b0, done = 1'b0, blank = 1'b0;
   logic [7:0]  adr = 8'h00, dbg_d = 8'h00, img = 8'h80, prot_q, code, st_dat;
   logic [31:0] wdat = 32'h0, rd, tmp, seed = 32'h22, dw;
   logic [15:0] a, st_adr;
   logic [2:0]  dly = 3'h0;
   logic [1:0]  sec_q;
   logic        blank_q, v;
   int          num_errors = 0, checks = 0, starts = 0, cnt = 0, s0;
   fcsp_op_t    st_op, op;
   wire [31:0]  dat_o;
   wire [15:0]  adr_o;
   wire [7:0]   dat_a;
   wire [1:0]   sec;
   wire         ack, start, abort;
   logic [7:0]  codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic fcsp_op_t exp_op(input logic [7:0] c);
      case (c)
         8'h05: return FCSP_OP_BLANK;
         8'h20: return FCSP_OP_BYTE;
         8'h25: return FCSP_OP_BURST;
         8'h40: return FCSP_OP_PAGE;
         8'h41: return FCSP_OP_MASS;
         default: return FCSP_OP_NONE;
      endcase
   endfunction : exp_op

   // Page erase is judged by the last byte of its page
   function automatic logic viol(input logic [15:0] ad, input logic [7:0] p,
                                 input logic [7:0] c);
      logic [15:0] pa;
      pa = (c == 8'h40) ? {ad[15:9], 9'h1ff} : ad;
      if (p[0] || c == 8'h05)
         return 1'b0;
      return c == 8'h41 || pa > {p[7:1], 9'h1ff};
   endfunction : viol

   function automatic logic [31:0] st(input logic [7:0] f);
      return {24'h0, f | {5'h0, blank_q, 2'h0}};
   endfunction : st

   initial
   begin
      forever #4 clk_i = ~clk_i;
   end

   fcsp_ctrl DUT
   (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .wb_cyc_i              (cyc),
      .wb_stb_i              (stb),
      .wb_we_i               (we),
      .wb_adr_i              (adr),
      .wb_sel_i              (4'hf),
      .wb_dat_i              (wdat),
      .wb_dat_o              (dat_o),
      .wb_ack_o              (ack),
      .nv_protect_image_i    (img),
      .nv_security_i         (2'h1),
      .dbg_prot_we_i         (dbg_we),
      .dbg_prot_data_i       (dbg_d),
      .clk_div_ready_i       (div_ok),
      .stop_mode_i           (stop),
      .arr_start_o           (start),
      .arr_abort_o           (abort),
      .arr_op_o              (op),
      .arr_addr_o            (adr_o),
      .arr_data_o            (dat_a),
      .arr_done_i            (done),
      .arr_blank_i           (blank),
      .security_state_code_o (sec)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Array stand-in: done 12 to 19 cycles after start, silent after abort
   always @(posedge clk_i)
   begin
      done <= !start && !abort && cnt == 1;
      if (start)
      begin
         starts <= starts + 1;
         st_op  <= op;
         st_adr <= adr_o;
         st_dat <= dat_a;
         cnt    <= 12 + dly;
      end
      else if (abort)
         cnt <= 0;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end

   // One classic cycle; waits for ack, then one idle cycle
   task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= ad;
      wdat <= d;
      do
         @(posedge clk_i);
      while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task rdchk(input logic [7:0] ad, input logic [31:0] e);
      bus(1'b0, ad, 32'h0);
      `CHK(rd, e)
   endtask : rdchk

   task launch(input logic [15:0] ad, input logic [7:0] c);
      dw = xs() & 32'hff;
      bus(1'b1, `FCSP_OFF_ADDR, {16'h0, ad});
      bus(1'b1, `FCSP_OFF_DATA, dw);
      bus(1'b1, `FCSP_OFF_CMD, {24'h0, c});
      bus(1'b1, `FCSP_OFF_STAT, 32'h80);
   endtask : launch

   // Polls status until complete reads 1, bounded
   task wait_ccf();
      int n;
      n = 0;
      do
      begin
         bus(1'b0, `FCSP_OFF_STAT, 32'h0);
         n++;
      end
      while (rd[6] !== 1'b1 && n < 40);
      if (rd[6] !== 1'b1)
      begin
         num_errors++;
         $display("Error %0t: complete flag never set", $time);
      end
   endtask : wait_ccf

   task dbg(input logic [7:0] d);
      dbg_we <= 1'b1;
      dbg_d  <= d;
      @(posedge clk_i);
      dbg_we <= 1'b0;
      @(posedge clk_i);
      prot_q = d;
   endtask : dbg

   task stop_test();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   // Watchdog, far beyond the few hundred cycles of the tests
   initial
   begin
      #200000;
      num_errors++;
      $display("Error %0t: timeout", $time);
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      tmp = xs();
      img <= {1'b1, tmp[5:0], 1'b0};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      prot_q  = img;
      sec_q   = 2'h1;
      blank_q = 1'b0;
      rdchk(`FCSP_OFF_PROT, {24'h0, img});
      rdchk(`FCSP_OFF_STAT, 32'hc0);
      rdchk(`FCSP_OFF_CMD, 32'h0);
      rdchk(8'h18, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         tmp = xs();
         tmp[7:0] = (i == 0) ? prot_q : tmp[7:0] & {7'h7f, tmp[8]};
         bus(1'b1, `FCSP_OFF_PROT, {24'h0, tmp[7:0]});
         if (!prot_q[0] && !tmp[0] && tmp[7:1] < prot_q[7:1])
            prot_q = tmp[7:0];
         rdchk(`FCSP_OFF_PROT, {24'h0, prot_q});
      end
      dbg(8'h03);
      rdchk(`FCSP_OFF_PROT, 32'h03);
      bus(1'b1, `FCSP_OFF_PROT, 32'h0);
      rdchk(`FCSP_OFF_PROT, 32'h03);
      dbg(8'h02);
      $display("test protect done");
      for (int i = 0; i < 10; i++)
      begin
         if (i == 5)
            dbg(8'h03);
         tmp   = xs();
         code  = codes[i % 5];
         a     = (i < 5 && tmp[20]) ? {6'h0, tmp[9:0]} : tmp[15:0];
         blank <= tmp[16] | (i >= 5);
         dly   <= tmp[19:17];
         v     = viol(a, prot_q, code);
         s0    = starts;
         launch(a, code);
         if (!v)
            rdchk(`FCSP_OFF_STAT, 32'h80);
         wait_ccf();
         if (v)
         begin
            `CHK(rd, st(8'he0))
            `CHK(starts, s0)
            bus(1'b1, `FCSP_OFF_STAT, 32'h20);
            rdchk(`FCSP_OFF_STAT, st(8'hc0));
         end
         else
         begin
            `CHK(st_op, exp_op(code))
            `CHK(st_adr, a)
            `CHK(st_dat, dw[7:0])
            blank_q = (code == 8'h05) & blank;
            sec_q   = blank_q ? 2'h2 : sec_q;
            `CHK(rd, st(8'hc0))
         end
      end
      rdchk(`FCSP_OFF_SEC, {30'h0, sec_q});
      `CHK(sec, sec_q)
      $display("test commands done");
      s0 = starts;
      launch(16'h0, 8'h33);
      rdchk(`FCSP_OFF_STAT, st(8'hd0));
      `CHK(starts, s0)
      bus(1'b1, `FCSP_OFF_STAT, 32'h4f);
      rdchk(`FCSP_OFF_STAT, st(8'hd0));
      bus(1'b1, `FCSP_OFF_STAT, 32'h10);
      rdchk(`FCSP_OFF_STAT, st(8'hc0));
      div_ok <= 1'b0;
      launch(16'h0, 8'h20);
      rdchk(`FCSP_OFF_STAT, st(8'hd0));
      div_ok <= 1'b1;
      bus(1'b1, `FCSP_OFF_STAT, 32'h10);
      // Second burst queues behind a slow first one, then chains
      dly <= 3'h7;
      s0 = starts;
      launch(16'h0, 8'h25);
      launch(16'h2, 8'h25);
      rdchk(`FCSP_OFF_STAT, 32'h0);
      wait_ccf();
      `CHK(starts, s0 + 2)
      `CHK(rd, st(8'hc0))
      launch(16'h0, 8'h41);
      blank_q = 1'b0;
      stop <= 1'b1;
      @(posedge clk_i);
      stop <= 1'b0;
      wait_ccf();
      `CHK(rd[4], 1'b1)
      `CHK(cnt, 0)
      $display("test errors done");
      stop_test();
   end
endmodule : fcsp_ctrl_tb

`default_nettype wire
